// File: rtl/plconn_ctrl.sv
// Purpose: connection failure and open connection handling toward phy managers
// Assumes: one event class at a time while ready is low, except cancel acks
// Notes: frame slots are loaded and issued by an outside scheduler
`timescale 1ns/100ps
`default_nettype none
// Function
// - expired timer on retry: delete, drop retry
// - report nexus loss for causing frame, remove
// - unissued same dest/proto frames: report, remove
// - issued same dest/proto: cancel open to phys
// - report issued ones only after cancel acks
// - retry failure status: nexus loss, open timeout or no destination
// - unable-to-connect reasons map to status codes
// - rate/protocol/stp failure reinitialises running timer
// - reported frame is removed from pending set
// - accept/reject opens goes to every phy
// - smp break to bound phy, else dropped
// - no open/frame after bad close until idle
// - normal close with pending opens may reopen
// - incoming opens never refused for outbound ones
// - own connection without frames gets closed
// - destination connection closed after linger time
// - disabled tx frames leads to close
// - idle timer starts on no-dest/open-timeout retry without connection
// - never-expiring timer keeps retries as retries
module plconn_ctrl
  import plconn_pkg::*;
#(
  parameter int TICK_CYC = NEXUS_TICK_CYC
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic frame_load_valid,
  input wire logic [SLOTW-1:0] frame_load_slot,
  input wire logic [DESTW-1:0] frame_load_dest,
  input wire logic [1:0] frame_load_proto,
  input wire logic open_issue_valid,
  input wire logic [SLOTW-1:0] open_issue_slot,
  input wire logic [PHYW-1:0] open_issue_phy,
  input wire logic tmr_cfg_valid,
  input wire logic [DESTW-1:0] tmr_cfg_dest,
  input wire logic [15:0] tmr_cfg_value,
  input wire logic retry_valid,
  input wire plconn_retry_t retry_reason,
  input wire logic [SLOTW-1:0] retry_slot,
  input wire logic utc_valid,
  input wire plconn_utc_t utc_reason,
  input wire logic [PHYW-1:0] utc_phy,
  input wire logic conn_open_valid,
  input wire logic [PHYW-1:0] conn_open_phy,
  input wire logic [DESTW-1:0] conn_open_dest,
  input wire logic conn_open_by_dest,
  input wire logic close_valid,
  input wire plconn_close_t close_reason,
  input wire logic [PHYW-1:0] close_phy,
  input wire logic disable_tx_valid,
  input wire logic [PHYW-1:0] disable_tx_phy,
  input wire logic ar_valid,
  input wire logic ar_accept,
  input wire logic smp_bind_valid,
  input wire logic smp_bind_en,
  input wire logic [SMPW-1:0] smp_bind_sm,
  input wire logic [PHYW-1:0] smp_bind_phy,
  input wire logic smp_break_valid,
  input wire logic [SMPW-1:0] smp_break_sm,
  output logic ready,
  output logic status_valid,
  output plconn_status_t status_code,
  output logic [SLOTW-1:0] status_slot,
  output logic retry_pass,
  output logic [NPHY-1:0] cancel_open,
  output logic [NPHY-1:0] ar_msg,
  output logic ar_msg_accept,
  output logic [NPHY-1:0] incoming_ok,
  output logic [NPHY-1:0] smp_break_msg,
  output logic [NPHY-1:0] tx_blocked,
  output logic [NPHY-1:0] reopen_hint,
  output logic [NPHY-1:0] close_conn
);
  typedef struct packed {
    plconn_cs_t cs;
    plconn_slot_t [NSLOT-1:0] slot;
    logic [DESTW-1:0] kdest;
    logic [1:0] kproto;
    logic [NPHY-1:0] cancel_wait;
    logic [NPHY-1:0] blocked;
    logic [NPHY-1:0] conn;
    logic [NPHY-1:0] by_dest;
    logic [NPHY-1:0] close_sent;
    logic [NPHY-1:0][DESTW-1:0] cdest;
    logic [NPHY-1:0][7:0] linger;
    logic [NSMP-1:0] smp_bound;
    logic [NSMP-1:0][PHYW-1:0] smp_phy;
    logic ready;
    logic status_valid;
    plconn_status_t status_code;
    logic [SLOTW-1:0] status_slot;
    logic retry_pass;
    logic [NPHY-1:0] cancel_open;
    logic [NPHY-1:0] ar_msg;
    logic ar_msg_accept;
    logic [NPHY-1:0] incoming_ok;
    logic [NPHY-1:0] smp_break_msg;
    logic [NPHY-1:0] reopen_hint;
    logic [NPHY-1:0] close_conn;
  } plconn_ctrl_t;

  plconn_ctrl_t s;
  plconn_ctrl_t next_s;
  plconn_tmr_t tmr_state [NDEST];
  logic [NDEST-1:0] tmr_never;
  logic [NDEST-1:0] tmr_start;
  logic [NDEST-1:0] tmr_init;
  logic [NDEST-1:0] tmr_remove;
  logic [DESTW-1:0] r_dest;
  logic r_fail;
  logic r_never;
  logic r_exp;
  logic r_created;
  logic u_hit;
  logic [SLOTW-1:0] u_slot;
  logic [DESTW-1:0] u_dest;

  genvar gd;
  generate
    for (gd = 0; gd < NDEST; gd++)
    begin : g_tmr
      plconn_nexus_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .cfg_load(tmr_cfg_valid && tmr_cfg_dest == DESTW'(gd)),
        .cfg_value(tmr_cfg_value),
        .start(tmr_start[gd]),
        .init(tmr_init[gd]),
        .remove(tmr_remove[gd]),
        .state(tmr_state[gd]),
        .never(tmr_never[gd])
      );
    end
  endgenerate

  function automatic plconn_status_t utc_map(input plconn_utc_t r);
    case (r)
      UTC_BAD_DEST: utc_map = ST_BAD_DEST;
      UTC_BREAK_RCV: utc_map = ST_BREAK_RCV;
      UTC_RATE: utc_map = ST_RATE;
      UTC_PORT_REQ: utc_map = ST_CANCEL_ACK;
      UTC_PROTO: utc_map = ST_PROTO;
      UTC_STP_BUSY: utc_map = ST_STP_BUSY;
      default: utc_map = ST_WRONG_DEST;
    endcase
  endfunction : utc_map

  assign r_dest = s.slot[retry_slot].dest;
  assign r_fail = retry_reason inside {RTY_NO_DEST, RTY_OPEN_TMO, RTY_PATH_BLK};
  assign r_never = tmr_state[r_dest] != TM_NONE && tmr_never[r_dest];
  assign r_exp = tmr_state[r_dest] == TM_EXP;
  assign r_created = tmr_state[r_dest] != TM_NONE;

  // first slot whose open went to the failing phy
  always_comb
  begin
    u_hit = 1'b0;
    u_slot = '0;
    for (int i = NSLOT - 1; i >= 0; i--)
      if (s.slot[i].valid && s.slot[i].issued && s.slot[i].phy == utc_phy)
      begin
        u_hit = 1'b1;
        u_slot = SLOTW'(i);
      end
  end
  assign u_dest = s.slot[u_slot].dest;

  always_comb
  begin
    logic found;
    logic dest_conn;
    logic any_unissued;
    logic [NPHY-1:0] busy;
    next_s = s;
    found = 1'b0;
    dest_conn = 1'b0;
    any_unissued = 1'b0;
    busy = '0;
    tmr_start = '0;
    tmr_init = '0;
    tmr_remove = '0;
    next_s.status_valid = 1'b0;
    next_s.retry_pass = 1'b0;
    next_s.cancel_open = '0;
    next_s.ar_msg = '0;
    next_s.smp_break_msg = '0;
    next_s.reopen_hint = '0;
    next_s.close_conn = '0;
    for (int p = 0; p < NPHY; p++)
    begin
      if (s.conn[p] && s.cdest[p] == r_dest)
        dest_conn = 1'b1;
      for (int i = 0; i < NSLOT; i++)
        if (s.slot[i].valid && s.slot[i].dest == s.cdest[p])
          busy[p] = 1'b1;
    end
    for (int i = 0; i < NSLOT; i++)
      if (s.slot[i].valid && !s.slot[i].issued)
        any_unissued = 1'b1;
    if (frame_load_valid && !s.slot[frame_load_slot].valid)
      next_s.slot[frame_load_slot] = '{valid: 1'b1, issued: 1'b0, phy: '0,
                                       dest: frame_load_dest, proto: frame_load_proto};
    if (open_issue_valid && s.slot[open_issue_slot].valid)
    begin
      next_s.slot[open_issue_slot].issued = 1'b1;
      next_s.slot[open_issue_slot].phy = open_issue_phy;
    end
    // idle-connection closing; each phy closes once per connection
    for (int p = 0; p < NPHY; p++)
      if (s.conn[p] && !s.close_sent[p] && !busy[p])
      begin
        if (!s.by_dest[p])
        begin
          next_s.close_conn[p] = 1'b1;
          next_s.close_sent[p] = 1'b1;
        end
        else if (s.linger[p] == LINGER_CYC)
        begin
          next_s.close_conn[p] = 1'b1;
          next_s.close_sent[p] = 1'b1;
        end
        else
          next_s.linger[p] = s.linger[p] + 8'h01;
      end
      else
        next_s.linger[p] = 8'h00;
    if (disable_tx_valid && s.conn[disable_tx_phy] && !s.close_sent[disable_tx_phy])
    begin
      next_s.close_conn[disable_tx_phy] = 1'b1;
      next_s.close_sent[disable_tx_phy] = 1'b1;
    end
    if (conn_open_valid)
    begin
      next_s.conn[conn_open_phy] = 1'b1;
      next_s.cdest[conn_open_phy] = conn_open_dest;
      next_s.by_dest[conn_open_phy] = conn_open_by_dest;
      next_s.close_sent[conn_open_phy] = 1'b0;
      next_s.linger[conn_open_phy] = 8'h00;
    end
    if (close_valid)
    begin
      next_s.conn[close_phy] = 1'b0;
      next_s.close_sent[close_phy] = 1'b0;
      if (close_reason inside {CLS_TMO, CLS_BRK_REQ, CLS_BRK_RCV})
        next_s.blocked[close_phy] = 1'b1;
      else if (close_reason == CLS_TTI)
        next_s.blocked[close_phy] = 1'b0;
      if (close_reason inside {CLS_NORMAL, CLS_TTI} && any_unissued)
        next_s.reopen_hint[close_phy] = 1'b1;
    end
    if (ar_valid)
    begin
      next_s.ar_msg = '1;
      next_s.ar_msg_accept = ar_accept;
      // per-phy admission follows only this setting, never outbound opens
      next_s.incoming_ok = {NPHY{ar_accept}};
    end
    if (smp_bind_valid)
    begin
      next_s.smp_bound[smp_bind_sm] = smp_bind_en;
      next_s.smp_phy[smp_bind_sm] = smp_bind_phy;
    end
    if (smp_break_valid && s.smp_bound[smp_break_sm])
      next_s.smp_break_msg[s.smp_phy[smp_break_sm]] = 1'b1;
    if (s.cs inside {CS_SWEEP_LOCAL, CS_WAIT_ACK} && utc_valid && utc_reason == UTC_PORT_REQ)
      next_s.cancel_wait[utc_phy] = 1'b0; // acks may land during the local sweep
    case (s.cs)
      CS_IDLE:
        if (retry_valid && s.slot[retry_slot].valid)
        begin
          if (!r_fail || r_never)
            next_s.retry_pass = 1'b1;
          else if (r_exp || !r_created)
          begin
            // no timer at all: fail with open timeout for an open-timeout retry, else no destination
            next_s.status_valid = 1'b1;
            next_s.status_slot = retry_slot;
            next_s.status_code = r_exp ? ST_NEXUS_LOSS :
              (retry_reason == RTY_OPEN_TMO ? ST_OPEN_TMO : ST_NO_DEST);
            next_s.slot[retry_slot].valid = 1'b0;
            if (r_exp)
            begin
              tmr_remove[r_dest] = 1'b1;
              next_s.kdest = r_dest;
              next_s.kproto = s.slot[retry_slot].proto;
              for (int i = 0; i < NSLOT; i++)
                if (s.slot[i].valid && s.slot[i].issued && i != int'(retry_slot) &&
                    s.slot[i].dest == r_dest &&
                    s.slot[i].proto == s.slot[retry_slot].proto)
                  next_s.cancel_open[s.slot[i].phy] = 1'b1;
              next_s.cancel_wait = next_s.cancel_open;
              next_s.cs = CS_SWEEP_LOCAL;
            end
          end
          else
          begin
            if (retry_reason != RTY_PATH_BLK && tmr_state[r_dest] == TM_IDLE && !dest_conn)
              tmr_start[r_dest] = 1'b1;
            next_s.retry_pass = 1'b1;
          end
        end
        else if (utc_valid && u_hit)
        begin
          next_s.status_valid = 1'b1;
          next_s.status_code = utc_map(utc_reason);
          next_s.status_slot = u_slot;
          next_s.slot[u_slot].valid = 1'b0;
          if (utc_reason inside {UTC_RATE, UTC_PROTO, UTC_STP_BUSY})
            tmr_init[u_dest] = 1'b1;
        end
      CS_SWEEP_LOCAL:
      begin
        for (int i = 0; i < NSLOT; i++)
          if (!found && s.slot[i].valid && !s.slot[i].issued &&
              s.slot[i].dest == s.kdest && s.slot[i].proto == s.kproto)
          begin
            found = 1'b1;
            next_s.status_valid = 1'b1;
            next_s.status_code = ST_NEXUS_LOSS;
            next_s.status_slot = SLOTW'(i);
            next_s.slot[i].valid = 1'b0;
          end
        if (!found)
          next_s.cs = CS_WAIT_ACK;
      end
      CS_WAIT_ACK:
      begin
        if (s.cancel_wait == '0)
          next_s.cs = CS_SWEEP_ISSUED;
      end
      CS_SWEEP_ISSUED:
      begin
        for (int i = 0; i < NSLOT; i++)
          if (!found && s.slot[i].valid &&
              s.slot[i].dest == s.kdest && s.slot[i].proto == s.kproto)
          begin
            found = 1'b1;
            next_s.status_valid = 1'b1;
            next_s.status_code = ST_NEXUS_LOSS;
            next_s.status_slot = SLOTW'(i);
            next_s.slot[i].valid = 1'b0;
          end
        if (!found)
          next_s.cs = CS_IDLE;
      end
      default: next_s.cs = CS_IDLE;
    endcase
    next_s.ready = (next_s.cs == CS_IDLE);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign ready = s.ready;
  assign status_valid = s.status_valid;
  assign status_code = s.status_code;
  assign status_slot = s.status_slot;
  assign retry_pass = s.retry_pass;
  assign cancel_open = s.cancel_open;
  assign ar_msg = s.ar_msg;
  assign ar_msg_accept = s.ar_msg_accept;
  assign incoming_ok = s.incoming_ok;
  assign smp_break_msg = s.smp_break_msg;
  assign tx_blocked = s.blocked;
  assign reopen_hint = s.reopen_hint;
  assign close_conn = s.close_conn;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_expired_loss: assert property (
    s.cs == CS_IDLE && retry_valid && s.slot[retry_slot].valid && r_fail && !r_never && r_exp
    |-> tmr_remove[r_dest] ##1 status_valid && status_code == ST_NEXUS_LOSS &&
        status_slot == $past(retry_slot) && !retry_pass)
    else $error("expired retry not reported");
  a_cancel_wait: assert property (
    s.cs == CS_SWEEP_LOCAL && $past(s.cs) == CS_IDLE |-> cancel_open == s.cancel_wait)
    else $error("cancel open mismatch");
  a_hold_report: assert property (
    s.cs == CS_WAIT_ACK && $past(s.cs) == CS_WAIT_ACK |-> !status_valid)
    else $error("report before cancel ack");
  a_cancel_ack_map: assert property (
    s.cs == CS_IDLE && !retry_valid && utc_valid && u_hit && utc_reason == UTC_PORT_REQ
    |=> status_valid && status_code == ST_CANCEL_ACK && !s.slot[status_slot].valid)
    else $error("cancel ack mapping wrong");
  a_rate_reinit: assert property (
    s.cs == CS_IDLE && !retry_valid && utc_valid && u_hit && utc_reason == UTC_RATE
    |-> tmr_init[u_dest]) else $error("timer not reinitialised");
  a_accept_all: assert property (
    ar_valid |=> ar_msg == '1 && incoming_ok == {NPHY{$past(ar_accept)}})
    else $error("accept reject not broadcast");
  a_smp_drop: assert property (
    smp_break_valid && !s.smp_bound[smp_break_sm] && !smp_bind_valid |=> smp_break_msg == '0)
    else $error("unbound smp break forwarded");
  a_block_hold: assert property (
    close_valid && close_reason == CLS_TMO |=> tx_blocked[$past(close_phy)])
    else $error("phy not blocked");
  a_disable_close: assert property (
    disable_tx_valid && s.conn[disable_tx_phy] && !s.close_sent[disable_tx_phy]
    |=> close_conn[$past(disable_tx_phy)]) else $error("no close after disable");

  c_expired: cover property (s.cs == CS_IDLE ##1 s.cs == CS_SWEEP_LOCAL);
  c_ack_sweep: cover property (s.cs == CS_WAIT_ACK ##1 s.cs == CS_SWEEP_ISSUED);
  c_linger: cover property (s.by_dest[1] && close_conn[1]);
endmodule : plconn_ctrl
`default_nettype wire

// File: rtl/plconn_pkg.sv
// Purpose: shared constants and types for the port connection control block
// Assumes: 100 MHz core_clk, small fixed numbers of phys, slots and destinations
// Notes: destinations are small indices standing in for full addresses
package plconn_pkg;
  localparam int NPHY = 4;
  localparam int NSLOT = 8;
  localparam int NDEST = 4;
  localparam int NSMP = 2;
  localparam int PHYW = 2;
  localparam int SLOTW = 3;
  localparam int DESTW = 2;
  localparam int SMPW = 1;
  localparam int CLK_NS = 10;
  localparam int NEXUS_TICK_NS = 1000000;
  localparam int NEXUS_TICK_CYC = NEXUS_TICK_NS / CLK_NS;
  localparam int LINGER_NS = 2000;
  localparam logic [7:0] LINGER_CYC = 8'(LINGER_NS / CLK_NS);
  localparam logic [15:0] TMR_NEVER = 16'hffff;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [19:0] PRE_RST = 20'h00000;

  typedef enum logic [2:0] {
    RTY_NO_DEST = 3'h0, RTY_OPEN_TMO = 3'h1, RTY_PATH_BLK = 3'h2, RTY_OTHER = 3'h3
  } plconn_retry_t;
  typedef enum logic [2:0] {
    UTC_BAD_DEST = 3'h0, UTC_BREAK_RCV = 3'h1, UTC_RATE = 3'h2, UTC_PORT_REQ = 3'h3,
    UTC_PROTO = 3'h4, UTC_STP_BUSY = 3'h5, UTC_WRONG_DEST = 3'h6
  } plconn_utc_t;
  typedef enum logic [2:0] {
    CLS_NORMAL = 3'h0, CLS_TTI = 3'h1, CLS_TMO = 3'h2, CLS_BRK_REQ = 3'h3, CLS_BRK_RCV = 3'h4
  } plconn_close_t;
  typedef enum logic [3:0] {
    ST_NEXUS_LOSS = 4'h0, ST_NO_DEST = 4'h1, ST_OPEN_TMO = 4'h2, ST_BAD_DEST = 4'h3,
    ST_BREAK_RCV = 4'h4, ST_RATE = 4'h5, ST_CANCEL_ACK = 4'h6, ST_PROTO = 4'h7,
    ST_STP_BUSY = 4'h8, ST_WRONG_DEST = 4'h9
  } plconn_status_t;
  typedef enum logic [1:0] {
    TM_NONE = 2'h0, TM_IDLE = 2'h1, TM_RUN = 2'h2, TM_EXP = 2'h3
  } plconn_tmr_t;
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0, CS_SWEEP_LOCAL = 2'h1, CS_WAIT_ACK = 2'h2, CS_SWEEP_ISSUED = 2'h3
  } plconn_cs_t;
  typedef struct packed {
    logic valid;
    logic issued;
    logic [PHYW-1:0] phy;
    logic [DESTW-1:0] dest;
    logic [1:0] proto;
  } plconn_slot_t;
endpackage : plconn_pkg

// File: rtl/plconn_nexus_timer.sv
// Purpose: one nexus loss timer for one destination
// Assumes: created by a config load, counts in ticks of TICK_CYC cycles
// Notes: an initial value of all ones never starts
`timescale 1ns/100ps
`default_nettype none
module plconn_nexus_timer
  import plconn_pkg::*;
#(
  parameter int TICK_CYC = NEXUS_TICK_CYC
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_load,
  input wire logic [15:0] cfg_value,
  input wire logic start,
  input wire logic init,
  input wire logic remove,
  output plconn_tmr_t state,
  output logic never
);
  typedef struct packed {
    plconn_tmr_t st;
    logic [15:0] init_val;
    logic [15:0] remain;
    logic [19:0] pre;
  } plconn_tm_state_t;

  plconn_tm_state_t s;
  plconn_tm_state_t next_s;

  always_comb
  begin
    next_s = s;
    case (s.st)
      TM_NONE:
        if (cfg_load)
        begin
          next_s.st = TM_IDLE;
          next_s.init_val = cfg_value;
          next_s.remain = cfg_value;
        end
      TM_IDLE:
        if (start && s.init_val != TMR_NEVER)
        begin
          next_s.st = TM_RUN;
          next_s.pre = PRE_RST;
        end
      TM_RUN:
        if (s.pre == 20'(TICK_CYC - 1))
        begin
          next_s.pre = PRE_RST;
          if (s.remain <= 16'h0001)
            next_s.st = TM_EXP;
          else
            next_s.remain = s.remain - 16'h0001;
        end
        else
          next_s.pre = s.pre + 20'h00001;
      TM_EXP: next_s.st = TM_EXP;
      default: next_s.st = TM_NONE;
    endcase
    if (init && s.st == TM_RUN)
    begin
      next_s.st = TM_IDLE;
      next_s.remain = s.init_val;
    end
    if (remove)
      next_s.st = TM_NONE;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '{st: TM_NONE, init_val: TMR_RST, remain: TMR_RST, pre: PRE_RST};
    else
      s <= next_s;
  end

  assign state = s.st;
  assign never = (s.init_val == TMR_NEVER);

  a_never_runs: assert property (@(posedge core_clk) disable iff (rst)
    s.st == TM_RUN |-> s.init_val != TMR_NEVER) else $error("never timer running");
  a_init_stops: assert property (@(posedge core_clk) disable iff (rst)
    init && !remove && s.st == TM_RUN |=> s.st == TM_IDLE && s.remain == $past(s.init_val))
    else $error("timer not reinitialised");
endmodule : plconn_nexus_timer
`default_nettype wire

// File: verif/plconn_phy_model.sv
// Purpose: stand-in for the per-phy managers that answer cancel opens
// Assumes: one cancel acknowledge per cancelled phy, DLY+1 cycles apart
// Notes: answers leave on the falling edge, like the bench stimulus
`timescale 1ns/100ps
`default_nettype none
module plconn_phy_model
  import plconn_pkg::*;
#(
  parameter int DLY = 3
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NPHY-1:0] cancel_open,
  output logic ack_valid,
  output logic [PHYW-1:0] ack_phy
);
  logic [NPHY-1:0] pend = '0;
  int cnt = 0;

  always @(negedge core_clk)
  begin : ack_gen
    logic [NPHY-1:0] p;
    int k;
    p = pend | cancel_open;
    k = -1;
    for (int i = NPHY - 1; i >= 0; i--)
      if (p[i])
        k = i;
    ack_valid <= 1'h0;
    // idle phy field never repeats a stale value
    ack_phy <= rst ? '0 : ~ack_phy;
    cnt <= (cnt > 0) ? cnt - 1 : 0;
    if (cnt == 0 && k >= 0 && !rst)
    begin
      ack_valid <= 1'h1;
      ack_phy <= PHYW'(k);
      p[k] = 1'h0;
      cnt <= DLY;
    end
    pend <= rst ? '0 : p;
  end
endmodule : plconn_phy_model
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the connection control block
// Assumes: nexus tick shortened to 4 cycles, cancel acks 4 cycles apart
// Notes: stimulus on the falling edge, outputs judged one edge later
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
  import plconn_pkg::*;
;
  localparam int LD = 0, IS = 1, CF = 2, RT = 3, UT = 4, CO = 5, CL = 6, AR = 7, BI = 8, BR = 9;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [9:0] vld = '0;
  logic ar_accept = 1'h0, smp_bind_en = 1'h0, conn_open_by_dest = 1'h0, disable_tx_valid = 1'h0;
  logic [SLOTW-1:0] frame_load_slot = '0, open_issue_slot = '0, retry_slot = '0;
  logic [DESTW-1:0] frame_load_dest = '0, tmr_cfg_dest = '0, conn_open_dest = '0;
  logic [PHYW-1:0] open_issue_phy = '0, tb_utc_phy = '0, conn_open_phy = '0, close_phy = '0;
  logic [PHYW-1:0] disable_tx_phy = '0, smp_bind_phy = '0;
  logic [1:0] frame_load_proto = '0;
  logic [15:0] tmr_cfg_value = '0;
  logic [SMPW-1:0] smp_bind_sm = '0, smp_break_sm = '0;
  plconn_retry_t retry_reason = RTY_NO_DEST;
  plconn_utc_t tb_utc_reason = UTC_BAD_DEST;
  plconn_close_t close_reason = CLS_NORMAL;
  wire logic frame_load_valid, open_issue_valid, tmr_cfg_valid, retry_valid, conn_open_valid;
  wire logic close_valid, ar_valid, smp_bind_valid, smp_break_valid, utc_valid;
  logic ack_valid, ready, status_valid, retry_pass, ar_msg_accept;
  logic [PHYW-1:0] ack_phy;
  plconn_status_t status_code;
  logic [SLOTW-1:0] status_slot;
  logic [NPHY-1:0] cancel_open, ar_msg, incoming_ok, smp_break_msg, tx_blocked, reopen_hint;
  logic [NPHY-1:0] close_conn;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_ack = 0;
  assign {smp_break_valid, smp_bind_valid, ar_valid, close_valid, conn_open_valid,
    retry_valid, tmr_cfg_valid, open_issue_valid, frame_load_valid} = {vld[9:5], vld[3:0]};
  // partner acks share the unable-to-connect inputs with the bench
  assign utc_valid = vld[UT] | ack_valid;
  wire plconn_utc_t utc_reason = ack_valid ? UTC_PORT_REQ : tb_utc_reason;
  wire logic [PHYW-1:0] utc_phy = ack_valid ? ack_phy : tb_utc_phy;

  plconn_ctrl #(.TICK_CYC(4)) DUT (.*);
  plconn_phy_model #(.DLY(3)) u_phy (.core_clk, .rst, .cancel_open, .ack_valid, .ack_phy);

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cyc++;
    if (ack_valid === 1'h1)
      n_ack++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // one strobe per call, a full low cycle between strobes
  task automatic pl(input int b);
    @(negedge core_clk);
    vld[b] = 1'h1;
    @(negedge core_clk);
    vld = '0;
  endtask : pl

  task automatic ld(input int s, input int d, input int p, input int ph);
    frame_load_slot = SLOTW'(s);
    frame_load_dest = DESTW'(d);
    frame_load_proto = 2'(p);
    pl(LD);
    open_issue_slot = SLOTW'(s);
    open_issue_phy = PHYW'(ph);
    if (ph >= 0)
      pl(IS);
  endtask : ld

  task automatic rt(input plconn_retry_t r, input int s);
    retry_reason = r;
    retry_slot = SLOTW'(s);
    pl(RT);
  endtask : rt

  task automatic ut(input plconn_utc_t r, input int ph);
    tb_utc_reason = r;
    tb_utc_phy = PHYW'(ph);
    pl(UT);
  endtask : ut

  task automatic cf(input int d, input logic [15:0] v);
    tmr_cfg_dest = DESTW'(d);
    tmr_cfg_value = v;
    pl(CF);
  endtask : cf

  task automatic st(input plconn_status_t c, input int s);
    `CHK({status_valid, status_code, status_slot}, {1'h1, c, SLOTW'(s)})
  endtask : st

  task automatic t_sweep;
    int k;
    cf(1, 16'h0001);
    ld(4, 1, 1, -1);
    rt(RTY_NO_DEST, 4);
    repeat (12) @(negedge core_clk);
    ld(0, 1, 0, -1);
    ld(1, 1, 0, -1);
    ld(2, 1, 0, 2);
    ld(3, 1, 0, 3);
    rt(RTY_PATH_BLK, 0);
    st(ST_NEXUS_LOSS, 0);
    `CHK({ready, cancel_open}, 5'h0c)
    k = 1;
    for (int i = 0; i < 60 && ready !== 1'h1; i++)
    begin
      @(negedge core_clk);
      if (status_valid === 1'h1)
      begin
        `CHK({status_code, status_slot}, {ST_NEXUS_LOSS, SLOTW'(k)})
        `CHK(n_ack >= 2, k >= 2)
        k++;
      end
    end
    `CHK(k, 4)
    ld(0, 1, 0, -1);
    rt(RTY_OPEN_TMO, 0);
    st(ST_OPEN_TMO, 0);
  endtask : t_sweep

  task automatic t_map;
    plconn_status_t e[7] = '{ST_BAD_DEST, ST_BREAK_RCV, ST_RATE, ST_CANCEL_ACK, ST_PROTO,
      ST_STP_BUSY, ST_WRONG_DEST};
    for (int r = 0; r < 7; r++)
    begin
      ld(5, 0, 0, 1);
      ut(plconn_utc_t'(r), 1);
      st(e[r], 5);
      ut(UTC_BAD_DEST, 1);
      `CHK(status_valid, 1'h0)
    end
  endtask : t_map

  task automatic t_timers;
    for (int i = 0; i < 2; i++)
    begin
      ld(7, 3, 0, -1);
      rt(plconn_retry_t'(i), 7);
      st(i ? ST_OPEN_TMO : ST_NO_DEST, 7);
    end
    cf(2, 16'hffff);
    ld(6, 2, 0, -1);
    rt(RTY_NO_DEST, 6);
    `CHK({retry_pass, status_valid}, 2'h2)
    cf(3, 16'h0010);
    ld(7, 3, 0, -1);
    rt(RTY_NO_DEST, 7);
    `CHK({retry_pass, status_valid}, 2'h2)
    ld(7, 3, 0, 0);
    repeat (20) @(negedge core_clk);
    ut(UTC_RATE, 0);
    st(ST_RATE, 7);
    // a timer left running would have expired by now
    repeat (80) @(negedge core_clk);
    ld(7, 3, 0, -1);
    rt(RTY_NO_DEST, 7);
    `CHK({retry_pass, status_valid}, 2'h2)
  endtask : t_timers

  task automatic t_misc;
    for (int a = 1; a >= 0; a--)
    begin
      ar_accept = 1'(a);
      pl(AR);
      `CHK({ar_msg, ar_msg_accept}, {4'hf, 1'(a)})
      @(negedge core_clk);
      `CHK(incoming_ok, {4{1'(a)}})
    end
    pl(BR);
    `CHK(smp_break_msg, 4'h0)
    smp_bind_en = 1'h1;
    smp_bind_sm = 1'h1;
    smp_bind_phy = 2'h2;
    pl(BI);
    smp_break_sm = 1'h1;
    pl(BR);
    `CHK(smp_break_msg, 4'h4)
    close_phy = 2'h1;
    for (int r = 2; r <= 4; r++)
    begin
      close_reason = plconn_close_t'(r);
      pl(CL);
      `CHK(tx_blocked, 4'h2)
      close_reason = CLS_NORMAL;
      pl(CL);
      `CHK(tx_blocked, 4'h2)
      `CHK(reopen_hint, 4'h2)
      close_reason = CLS_TTI;
      pl(CL);
      `CHK(tx_blocked, 4'h0)
    end
  endtask : t_misc

  task automatic t_conn;
    int k;
    pl(CO);
    @(negedge core_clk);
    `CHK(close_conn, 4'h1)
    conn_open_phy = 2'h1;
    conn_open_by_dest = 1'h1;
    pl(CO);
    k = 0;
    while (close_conn !== 4'h2 && k < 300)
    begin
      @(negedge core_clk);
      k++;
    end
    `CHK(k >= 32'(LINGER_CYC) && k < 300, 1'h1)
    conn_open_phy = 2'h2;
    pl(CO);
    disable_tx_phy = 2'h2;
    disable_tx_valid = 1'h1;
    @(negedge core_clk);
    disable_tx_valid = 1'h0;
    `CHK(close_conn, 4'h4)
  endtask : t_conn

  initial
  begin
    repeat (20) @(negedge core_clk);
    rst = 1'h0;
    t_sweep();
    t_map();
    t_timers();
    t_misc();
    t_conn();
    test_done();
  end
endmodule : testbench
`default_nettype wire
